// ### design/i2c_rx_host.sv
// Purpose: Runs the master-receive software sequence on the two-wire controller
// Assumes: Device registers on the device APB, same clock as pclk
// Notes:   Commands and results through own APB slave registers

`timescale 1ns/1ps
`default_nettype none

// Contract
// - Address goes to data_buffer only after status_one shows start_sent_flag.
// - Ten-bit read: header 11110xx0, low 8 bits, restart, header 11110xx1.
// - After header_sent_flag, status_one is read then second address byte written.
// - address_sent_flag is cleared by reading status_one then status_two.
// - Seven-bit read address byte carries direction bit 1 in bit 0.
// - Ten-bit read requests restart after first address phase, then read header.
// - ack_enable cleared when byte N-1 arrives, stop requested after reading it.
// - Single-byte read clears ack_enable and requests stop right after addressing.
// - Each received byte is serviced before the current byte ends.
// - On nack in master mode a stop is requested by software.
module i2c_rx_host #(
	parameter int MAX_BYTES = 16
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Command APB slave
	input  wire logic        s_psel,
	input  wire logic        s_penable,
	input  wire logic        s_pwrite,
	input  wire logic [11:0] s_paddr,
	input  wire logic [31:0] s_pwdata,
	output logic [31:0]      s_prdata,
	output logic             s_pready,
	output logic             s_pslverr,
	// Device APB master
	output logic             m_psel,
	output logic             m_penable,
	output logic             m_pwrite,
	output logic [11:0]      m_paddr,
	output logic [31:0]      m_pwdata,
	input  wire logic [31:0] m_prdata,
	input  wire logic        m_pready
);

	localparam int IDX_W = $clog2(MAX_BYTES);
	localparam int CNT_W = $clog2(MAX_BYTES + 1);
	localparam int DATA_END = int'(i2c_rx_host_pkg::REG_DATA_BASE) + 4 * MAX_BYTES;

	if (MAX_BYTES < 2 || MAX_BYTES > 256)
	begin : g_bad_max
		$error("MAX_BYTES must lie in 2..256");
	end

	typedef enum logic [14:0] {
		S_IDLE       = 15'h0001,
		S_SETUP2     = 15'h0002,
		S_POLL_BUSY  = 15'h0004,
		S_START      = 15'h0008,
		S_WAIT_SB    = 15'h0010,
		S_WR_HDR     = 15'h0020,
		S_WAIT_HDR   = 15'h0040,
		S_WR_ADDR2   = 15'h0080,
		S_WAIT_ADDR  = 15'h0100,
		S_RD_STS2    = 15'h0200,
		S_LAST_SETUP = 15'h0400,
		S_WAIT_RX    = 15'h0800,
		S_ACK_OFF    = 15'h1000,
		S_RD_DATA    = 15'h2000,
		S_ABORT      = 15'h4000
	} state_t;

	state_t             state_q;
	state_t             state_d;
	logic               wait_q;
	logic               phase_q;
	logic               phase_d;
	logic [9:0]         addr_q;
	logic [CNT_W-1:0]   count_q;
	logic [CNT_W-1:0]   remain_q;
	logic [IDX_W-1:0]   idx_q;
	logic [CNT_W-1:0]   got_q;
	logic               ten_q;
	logic               evt_en_q;
	logic               err_en_q;
	logic               done_q;
	logic               ackf_q;
	logic               arb_q;
	logic               buse_q;
	logic               set_done;
	logic               set_ackf;
	logic               set_arb;
	logic               set_buse;
	logic               store;
	logic               sts1_read;
	logic               first_hdr;
	logic               wr_acc;
	logic               setup_acc;
	logic               go;
	logic               data_hit;
	logic               reg_hit;
	logic [IDX_W-1:0]   rd_idx;
	logic [7:0]         rd_byte;
	logic [31:0]        status_word;
	logic [31:0]        c1_base;

	dev_access_if acc ();

	apb_master_engine u_engine (
		.pclk      (pclk),
		.presetn   (presetn),
		.acc       (acc.engine),
		.m_psel    (m_psel),
		.m_penable (m_penable),
		.m_pwrite  (m_pwrite),
		.m_paddr   (m_paddr),
		.m_pwdata  (m_pwdata),
		.m_prdata  (m_prdata),
		.m_pready  (m_pready)
	);

	rx_store #(
		.DEPTH (MAX_BYTES),
		.IDX_W (IDX_W)
	) u_store (
		.pclk    (pclk),
		.wr_en   (store),
		.wr_idx  (idx_q),
		.wr_byte (acc.rdata[7:0]),
		.rd_idx  (rd_idx),
		.rd_byte (rd_byte)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Own APB slave: zero wait states, data latched in the setup cycle

	assign s_pready  = 1'b1;
	assign setup_acc = s_psel && !s_penable;
	assign wr_acc    = s_psel && s_penable && s_pwrite;
	assign data_hit  = ({20'h00000, s_paddr} >= 32'(i2c_rx_host_pkg::REG_DATA_BASE))
		&& ({20'h00000, s_paddr} < 32'(DATA_END)) && (s_paddr[1:0] == 2'h0);
	assign reg_hit   = (s_paddr == i2c_rx_host_pkg::REG_CTRL)
		|| (s_paddr == i2c_rx_host_pkg::REG_ADDR)
		|| (s_paddr == i2c_rx_host_pkg::REG_COUNT)
		|| (s_paddr == i2c_rx_host_pkg::REG_STATUS);
	assign s_pslverr = s_psel && s_penable && !data_hit && !reg_hit;
	assign rd_idx    = IDX_W'((s_paddr - i2c_rx_host_pkg::REG_DATA_BASE) >> 2);

	// Go is refused while busy, with a zero count, or with a count the store cannot hold
	assign go = wr_acc && (s_paddr == i2c_rx_host_pkg::REG_CTRL)
		&& s_pwdata[i2c_rx_host_pkg::CTRL_GO] && (state_q == S_IDLE)
		&& (count_q != '0) && (count_q <= CNT_W'(MAX_BYTES));

	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[i2c_rx_host_pkg::ST_BUSY]     = (state_q != S_IDLE);
		status_word[i2c_rx_host_pkg::ST_DONE]     = done_q;
		status_word[i2c_rx_host_pkg::ST_ACK_FAIL] = ackf_q;
		status_word[i2c_rx_host_pkg::ST_ARB_LOST] = arb_q;
		status_word[i2c_rx_host_pkg::ST_BUS_ERR]  = buse_q;
		status_word[i2c_rx_host_pkg::ST_COUNT +: CNT_W] = got_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_prdata <= i2c_rx_host_pkg::RESET_WORD;
		else if (setup_acc)
		begin
			s_prdata <= 32'h0000_0000;
			if (data_hit)
				s_prdata <= {24'h000000, rd_byte};
			else if (s_paddr == i2c_rx_host_pkg::REG_CTRL)
				s_prdata <= {28'h0000000, err_en_q, evt_en_q, ten_q, 1'b0};
			else if (s_paddr == i2c_rx_host_pkg::REG_ADDR)
				s_prdata <= {22'h000000, addr_q};
			else if (s_paddr == i2c_rx_host_pkg::REG_COUNT)
				s_prdata <= {{(32 - CNT_W){1'b0}}, count_q};
			else if (s_paddr == i2c_rx_host_pkg::REG_STATUS)
				s_prdata <= status_word;
		end
	end

	// Configuration is frozen during a sequence
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_q   <= 10'h000;
			count_q  <= '0;
			ten_q    <= 1'b0;
			evt_en_q <= 1'b0;
			err_en_q <= 1'b0;
		end
		else if (wr_acc && state_q == S_IDLE)
		begin
			if (s_paddr == i2c_rx_host_pkg::REG_ADDR)
				addr_q <= s_pwdata[9:0];
			if (s_paddr == i2c_rx_host_pkg::REG_COUNT)
				count_q <= s_pwdata[CNT_W-1:0];
			if (s_paddr == i2c_rx_host_pkg::REG_CTRL)
			begin
				ten_q    <= s_pwdata[i2c_rx_host_pkg::CTRL_TEN];
				evt_en_q <= s_pwdata[i2c_rx_host_pkg::CTRL_EVT];
				err_en_q <= s_pwdata[i2c_rx_host_pkg::CTRL_ERR];
			end
		end
	end

	// Sticky results: write one to clear, a new event wins over the clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_q <= 1'b0;
			ackf_q <= 1'b0;
			arb_q  <= 1'b0;
			buse_q <= 1'b0;
		end
		else
		begin
			if (wr_acc && s_paddr == i2c_rx_host_pkg::REG_STATUS)
			begin
				done_q <= set_done || (done_q && !s_pwdata[i2c_rx_host_pkg::ST_DONE]);
				ackf_q <= set_ackf || (ackf_q && !s_pwdata[i2c_rx_host_pkg::ST_ACK_FAIL]);
				arb_q  <= set_arb || (arb_q && !s_pwdata[i2c_rx_host_pkg::ST_ARB_LOST]);
				buse_q <= set_buse || (buse_q && !s_pwdata[i2c_rx_host_pkg::ST_BUS_ERR]);
			end
			else
			begin
				done_q <= done_q || set_done;
				ackf_q <= ackf_q || set_ackf;
				arb_q  <= arb_q || set_arb;
				buse_q <= buse_q || set_buse;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Device access issued on entering a state and again after each done while it stays, next state taken on done

	assign first_hdr = ten_q && !phase_q;
	assign sts1_read = acc.done && (state_q == S_WAIT_SB || state_q == S_WAIT_HDR
		|| state_q == S_WAIT_ADDR || state_q == S_WAIT_RX);
	assign acc.req   = (state_q != S_IDLE) && !wait_q;

	always_comb
	begin
		c1_base = 32'h0000_0000;
		c1_base[i2c_rx_host_pkg::C1_ENABLE] = 1'b1;
		acc.write = 1'b0;
		acc.addr  = i2c_rx_host_pkg::DEV_STATUS_ONE;
		acc.wdata = 32'h0000_0000;
		case (state_q)
			S_SETUP2:
			begin
				acc.write = 1'b1;
				acc.addr  = i2c_rx_host_pkg::DEV_CONTROL_TWO;
				acc.wdata[i2c_rx_host_pkg::C2_EVT_IRQ] = evt_en_q;
				acc.wdata[i2c_rx_host_pkg::C2_ERR_IRQ] = err_en_q;
			end
			S_POLL_BUSY, S_RD_STS2:
				acc.addr = i2c_rx_host_pkg::DEV_STATUS_TWO;
			S_START:
			begin
				acc.write = 1'b1;
				acc.addr  = i2c_rx_host_pkg::DEV_CONTROL_ONE;
				acc.wdata = c1_base;
				acc.wdata[i2c_rx_host_pkg::C1_START] = 1'b1;
				acc.wdata[i2c_rx_host_pkg::C1_ACK]   = (count_q > 1);
			end
			S_WR_HDR:
			begin
				acc.write = 1'b1;
				acc.addr  = i2c_rx_host_pkg::DEV_DATA_BUFFER;
				if (ten_q)
					acc.wdata[7:0] = {i2c_rx_host_pkg::HDR_PREFIX, addr_q[9:8], phase_q};
				else
					acc.wdata[7:0] = {addr_q[6:0], 1'b1};
			end
			S_WR_ADDR2:
			begin
				acc.write = 1'b1;
				acc.addr  = i2c_rx_host_pkg::DEV_DATA_BUFFER;
				acc.wdata[7:0] = addr_q[7:0];
			end
			S_LAST_SETUP, S_ABORT:
			begin
				acc.write = 1'b1;
				acc.addr  = i2c_rx_host_pkg::DEV_CONTROL_ONE;
				acc.wdata = c1_base;
				acc.wdata[i2c_rx_host_pkg::C1_STOP] = 1'b1;
			end
			S_ACK_OFF:
			begin
				acc.write = 1'b1;
				acc.addr  = i2c_rx_host_pkg::DEV_CONTROL_ONE;
				acc.wdata = c1_base;
			end
			S_RD_DATA:
				acc.addr = i2c_rx_host_pkg::DEV_DATA_BUFFER;
			default:
				acc.addr = i2c_rx_host_pkg::DEV_STATUS_ONE;
		endcase
	end

	always_comb
	begin
		state_d  = state_q;
		phase_d  = phase_q;
		set_done = 1'b0;
		set_ackf = 1'b0;
		set_arb  = 1'b0;
		set_buse = sts1_read && acc.rdata[i2c_rx_host_pkg::S1_BUS_ERR];
		store    = 1'b0;
		if (state_q == S_IDLE)
		begin
			phase_d = 1'b0;
			if (go)
				state_d = S_SETUP2;
		end
		else if (sts1_read && acc.rdata[i2c_rx_host_pkg::S1_ACK_FAIL])
		begin
			set_ackf = 1'b1;
			state_d  = S_ABORT;
		end
		else if (sts1_read && acc.rdata[i2c_rx_host_pkg::S1_ARB_LOSS])
		begin
			// Device already left master mode; nothing to stop
			set_arb  = 1'b1;
			set_done = 1'b1;
			state_d  = S_IDLE;
		end
		else if (acc.done)
		begin
			case (state_q)
				S_SETUP2:
					state_d = S_POLL_BUSY;
				S_POLL_BUSY:
					if (!acc.rdata[i2c_rx_host_pkg::S2_BUSY])
						state_d = S_START;
				S_START:
					state_d = S_WAIT_SB;
				S_WAIT_SB:
					if (acc.rdata[i2c_rx_host_pkg::S1_START_SENT])
						state_d = S_WR_HDR;
				S_WR_HDR:
					state_d = first_hdr ? S_WAIT_HDR : S_WAIT_ADDR;
				S_WAIT_HDR:
					if (acc.rdata[i2c_rx_host_pkg::S1_HDR_SENT])
						state_d = S_WR_ADDR2;
				S_WR_ADDR2:
					state_d = S_WAIT_ADDR;
				S_WAIT_ADDR:
					if (acc.rdata[i2c_rx_host_pkg::S1_ADDR_SENT])
						state_d = S_RD_STS2;
				S_RD_STS2:
					if (first_hdr)
					begin
						phase_d = 1'b1;
						state_d = S_START;
					end
					else if (count_q == 1)
						state_d = S_LAST_SETUP;
					else
						state_d = S_WAIT_RX;
				S_LAST_SETUP:
					state_d = S_WAIT_RX;
				S_WAIT_RX:
					if (acc.rdata[i2c_rx_host_pkg::S1_RX_FULL])
						state_d = (remain_q == 2) ? S_ACK_OFF : S_RD_DATA;
				S_ACK_OFF:
					state_d = S_RD_DATA;
				S_RD_DATA:
				begin
					store = 1'b1;
					if (remain_q == 1)
					begin
						set_done = 1'b1;
						state_d  = S_IDLE;
					end
					else if (remain_q == 2)
						state_d = S_LAST_SETUP;
					else
						state_d = S_WAIT_RX;
				end
				S_ABORT:
				begin
					set_done = 1'b1;
					state_d  = S_IDLE;
				end
				default:
					state_d = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= S_IDLE;
			phase_q <= 1'b0;
			wait_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			phase_q <= phase_d;
			if (acc.req)
				wait_q <= 1'b1;
			else if (acc.done)
				wait_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			remain_q <= '0;
			idx_q    <= '0;
			got_q    <= '0;
		end
		else if (go)
		begin
			remain_q <= count_q;
			idx_q    <= '0;
			got_q    <= '0;
		end
		else if (store)
		begin
			remain_q <= remain_q - 1'b1;
			idx_q    <= idx_q + 1'b1;
			got_q    <= got_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_addr_after_start: assert property (acc.req && state_q == S_WR_HDR |->
		$past(state_q) == S_WAIT_SB && $past(acc.rdata[i2c_rx_host_pkg::S1_START_SENT]))
		else $error("address written without start_sent seen");
	a_header_format: assert property (acc.req && state_q == S_WR_HDR && ten_q |->
		acc.wdata[7:3] == i2c_rx_host_pkg::HDR_PREFIX && acc.wdata[2:1] == addr_q[9:8]
		&& acc.wdata[0] == phase_q)
		else $error("ten-bit header malformed");
	a_second_byte: assert property (acc.req && state_q == S_WR_ADDR2 |->
		acc.wdata[7:0] == addr_q[7:0] && $past(state_q) == S_WAIT_HDR)
		else $error("second address byte out of order");
	a_status_order: assert property (acc.req && state_q == S_RD_STS2 |->
		$past(state_q) == S_WAIT_ADDR && $past(acc.rdata[i2c_rx_host_pkg::S1_ADDR_SENT]))
		else $error("status_two read before status_one");
	a_read_dir: assert property (acc.req && state_q == S_WR_HDR && !ten_q |->
		acc.wdata[0] == 1'b1)
		else $error("read direction bit not set");
	a_restart: assert property (acc.done && state_q == S_RD_STS2 && first_hdr |=>
		state_q == S_START && phase_q ##1 acc.wdata[i2c_rx_host_pkg::C1_START])
		else $error("ten-bit restart missing");
	a_nack_setup: assert property (acc.done && state_q == S_RD_DATA && remain_q == 2 |=>
		acc.req && acc.wdata[i2c_rx_host_pkg::C1_STOP] && !acc.wdata[i2c_rx_host_pkg::C1_ACK])
		else $error("stop not requested after byte N-1");
	a_single_byte: assert property (acc.done && state_q == S_RD_STS2 && !first_hdr
		&& count_q == 1 |=> state_q == S_LAST_SETUP)
		else $error("single-byte setup skipped");
	a_nack_stop: assert property (sts1_read && acc.rdata[i2c_rx_host_pkg::S1_ACK_FAIL] |=>
		state_q == S_ABORT && acc.req && acc.wdata[i2c_rx_host_pkg::C1_STOP])
		else $error("no stop after acknowledge failure");
	a_apb_hold: assert property (m_psel && m_penable && !m_pready |=>
		m_psel && m_penable && $stable(m_paddr) && $stable(m_pwdata) && $stable(m_pwrite))
		else $error("device request changed while waiting");

endmodule

`default_nettype wire

// ### design/i2c_rx_host_pkg.sv
// Purpose: Shared constants for the two-wire master-receive host sequencer
// Assumes: Device registers are word registers on the device's own APB
// Notes:   Device map and all bit positions are placed here once

package i2c_rx_host_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	////////////////////////////////////////////////////////////////////////////////
	// Device register map (byte addresses)
	localparam logic [11:0] DEV_CONTROL_ONE = 12'h000;
	localparam logic [11:0] DEV_CONTROL_TWO = 12'h004;
	localparam logic [11:0] DEV_DATA_BUFFER = 12'h010;
	localparam logic [11:0] DEV_STATUS_ONE  = 12'h014;
	localparam logic [11:0] DEV_STATUS_TWO  = 12'h018;

	// control_one fields
	localparam int unsigned C1_ENABLE = 0;
	localparam int unsigned C1_START  = 8;
	localparam int unsigned C1_STOP   = 9;
	localparam int unsigned C1_ACK    = 10;
	// control_two fields
	localparam int unsigned C2_ERR_IRQ = 8;
	localparam int unsigned C2_EVT_IRQ = 9;
	// status_one fields
	localparam int unsigned S1_START_SENT = 0;
	localparam int unsigned S1_ADDR_SENT  = 1;
	localparam int unsigned S1_HDR_SENT   = 3;
	localparam int unsigned S1_RX_FULL    = 6;
	localparam int unsigned S1_BUS_ERR    = 8;
	localparam int unsigned S1_ARB_LOSS   = 9;
	localparam int unsigned S1_ACK_FAIL   = 10;
	// status_two fields
	localparam int unsigned S2_BUSY = 1;

	// Ten-bit header prefix
	localparam logic [4:0] HDR_PREFIX = 5'h1e;

	////////////////////////////////////////////////////////////////////////////////
	// Own command registers (byte addresses)
	localparam logic [11:0] REG_CTRL      = 12'h000;
	localparam logic [11:0] REG_ADDR      = 12'h004;
	localparam logic [11:0] REG_COUNT     = 12'h008;
	localparam logic [11:0] REG_STATUS    = 12'h00c;
	localparam logic [11:0] REG_DATA_BASE = 12'h040;

	localparam int unsigned CTRL_GO  = 0;
	localparam int unsigned CTRL_TEN = 1;
	localparam int unsigned CTRL_EVT = 2;
	localparam int unsigned CTRL_ERR = 3;

	localparam int unsigned ST_BUSY     = 0;
	localparam int unsigned ST_DONE     = 1;
	localparam int unsigned ST_ACK_FAIL = 2;
	localparam int unsigned ST_ARB_LOST = 3;
	localparam int unsigned ST_BUS_ERR  = 4;
	localparam int unsigned ST_COUNT    = 8;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage

// ### design/dev_access_if.sv
// Purpose: Request and answer carrier between sequencer and APB engine
// Assumes: One request at a time; req is a one-cycle pulse
// Notes:   done pulses once per request together with rdata

`timescale 1ns/1ps
`default_nettype none

interface dev_access_if;
	logic        req;
	logic        write;
	logic [11:0] addr;
	logic [31:0] wdata;
	logic        done;
	logic [31:0] rdata;

	modport requester (output req, output write, output addr, output wdata,
		input done, input rdata);
	modport engine (input req, input write, input addr, input wdata,
		output done, output rdata);
endinterface

`default_nettype wire

// ### design/apb_master_engine.sv
// Purpose: APB master toward the device registers
// Assumes: Requests arrive only while the engine is idle
// Notes:   Waits on pready without limit

`timescale 1ns/1ps
`default_nettype none

module apb_master_engine (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Sequencer side
	dev_access_if.engine     acc,
	// Device APB
	output logic             m_psel,
	output logic             m_penable,
	output logic             m_pwrite,
	output logic [11:0]      m_paddr,
	output logic [31:0]      m_pwdata,
	input  wire logic [31:0] m_prdata,
	input  wire logic        m_pready
);

	logic finish;

	assign finish = m_psel && m_penable && m_pready;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			m_psel    <= 1'b0;
			m_penable <= 1'b0;
		end
		else if (!m_psel)
			m_psel <= acc.req;
		else if (!m_penable)
			m_penable <= 1'b1;
		else if (m_pready)
		begin
			m_psel    <= 1'b0;
			m_penable <= 1'b0;
		end
	end

	// Request held unchanged until the sampling edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			m_pwrite <= 1'b0;
			m_paddr  <= 12'h000;
			m_pwdata <= i2c_rx_host_pkg::RESET_WORD;
		end
		else if (acc.req && !m_psel)
		begin
			m_pwrite <= acc.write;
			m_paddr  <= acc.addr;
			m_pwdata <= acc.wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc.done  <= 1'b0;
			acc.rdata <= i2c_rx_host_pkg::RESET_WORD;
		end
		else
		begin
			acc.done <= finish;
			if (finish && !m_pwrite)
				acc.rdata <= m_prdata;
		end
	end

endmodule

`default_nettype wire

// ### design/rx_store.sv
// Purpose: Holds received bytes for software to read back
// Assumes: One write port from the sequencer, one read port for APB
// Notes:   Contents are not reset; the count tells what is valid

`timescale 1ns/1ps
`default_nettype none

module rx_store #(
	parameter int DEPTH = 16,
	parameter int IDX_W = 4
) (
	// Clock
	input  wire logic             pclk,
	// Write side
	input  wire logic             wr_en,
	input  wire logic [IDX_W-1:0] wr_idx,
	input  wire logic [7:0]       wr_byte,
	// Read side
	input  wire logic [IDX_W-1:0] rd_idx,
	output logic [7:0]            rd_byte
);

	if (DEPTH < 1 || DEPTH > (1 << IDX_W))
	begin : g_bad_size
		$error("rx_store DEPTH does not fit IDX_W");
	end

	logic [7:0] mem [DEPTH];

	always_ff @(posedge pclk)
	begin
		if (wr_en)
			mem[wr_idx] <= wr_byte;
	end

	assign rd_byte = mem[rd_idx];

endmodule

`default_nettype wire

// ### dv/dev_model.sv
// Purpose: Behavioural two-wire controller seen through its registers
// Assumes: Slave byte i reads 8'h30+i; fault picks one error at addressing
// Notes:   Slow mode inserts one wait state on every access

`timescale 1ns/1ps
`default_nettype none

module dev_model (
	// Clock, reset, scenario control
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        slow,
	input  wire logic [1:0]  fault,
	// Device APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	// Observation
	output logic [23:0]      wlog_q,
	output logic [7:0]       nbyte_q,
	output logic             stop_q,
	output logic             err_irq
);
	logic [10:0] s1_q;
	logic        ms_q;
	logic        rd1_q;
	logic        ack_q;
	logic        stp_q;
	logic        nk_q;
	logic        rw_q;
	logic        wt_q;
	logic        eirq_en_q;
	logic [31:0] val;
	logic        acc;

	assign pready = psel & penable & (~slow | wt_q);
	assign acc = pready;
	assign err_irq = eirq_en_q & (|s1_q[10:8]);
	assign val = paddr == i2c_rx_host_pkg::DEV_STATUS_ONE ? {21'h0, s1_q}
		: paddr == i2c_rx_host_pkg::DEV_STATUS_TWO ? {30'h0, ms_q, 1'b0}
		: {24'h0, 8'h2f + nbyte_q};
	// Outside the answer the read lines carry garbage, not the last value
	assign prdata = pready ? val : ~val;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			wt_q <= 1'b0;
		else
			wt_q <= psel & penable & ~wt_q;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			s1_q <= 11'h0;
			{ms_q, rd1_q, ack_q, stp_q, nk_q, rw_q, stop_q, eirq_en_q} <= 8'h0;
			wlog_q <= 24'h0;
			nbyte_q <= 8'h0;
		end
		else if (acc)
		begin
			rd1_q <= ~pwrite & (paddr == i2c_rx_host_pkg::DEV_STATUS_ONE);
			if (pwrite && paddr == i2c_rx_host_pkg::DEV_CONTROL_TWO)
			begin
				{wlog_q, nbyte_q, stop_q} <= 33'h0;
				eirq_en_q <= pwdata[i2c_rx_host_pkg::C2_ERR_IRQ];
				s1_q[10:8] <= 3'h0;
			end
			if (pwrite && paddr == i2c_rx_host_pkg::DEV_CONTROL_ONE)
			begin
				ack_q <= pwdata[i2c_rx_host_pkg::C1_ACK];
				stp_q <= pwdata[i2c_rx_host_pkg::C1_STOP];
				if (pwdata[8])
					{s1_q[0], ms_q} <= 2'h3;
				if (pwdata[9] & s1_q[10])
					{stop_q, ms_q} <= 2'h2;
			end
			if (pwrite && paddr == i2c_rx_host_pkg::DEV_DATA_BUFFER && rd1_q)
			begin
				wlog_q <= {wlog_q[15:0], pwdata[7:0]};
				rw_q <= ~s1_q[3] & pwdata[0];
				s1_q[0] <= 1'b0;
				if (s1_q[3])
					s1_q[3:1] <= 3'h1;
				else if (pwdata[7:3] == i2c_rx_host_pkg::HDR_PREFIX && !pwdata[0])
					s1_q[3] <= 1'b1;
				else
				begin
					s1_q[1] <= fault[1] | ~fault[0];
					s1_q[10:8] <= {fault == 2'h1, fault == 2'h2, fault == 2'h3};
					if (fault == 2'h2)
						ms_q <= 1'b0;
				end
			end
			if (!pwrite && paddr == i2c_rx_host_pkg::DEV_STATUS_TWO && rd1_q && s1_q[1])
			begin
				s1_q[1] <= 1'b0;
				s1_q[6] <= rw_q;
				nbyte_q <= nbyte_q + 8'(rw_q);
				nk_q <= ~ack_q;
			end
			if (!pwrite && paddr == i2c_rx_host_pkg::DEV_DATA_BUFFER && s1_q[6])
			begin
				s1_q[6] <= ~nk_q;
				nbyte_q <= nbyte_q + {7'h0, ~nk_q};
				nk_q <= ~ack_q;
				if (nk_q & stp_q)
					{stop_q, ms_q} <= 2'h2;
			end
		end
endmodule

`default_nettype wire

// ### dv/i2c_rx_host_tb_top.sv
// Purpose: Self-checking bench for the master-receive host sequencer
// Assumes: Device stands in as dev_model
// Notes:   Rows hold ten-bit flag, address, count, wait states, address bytes

`timescale 1ns/1ps
`default_nettype none

module i2c_rx_host_tb_top;
	typedef struct packed {logic ten; logic [9:0] a; logic [4:0] n; logic sl; logic [23:0] w;} row_t;
	localparam row_t ROWS [3] = '{{1'b0, 10'h052, 5'd1, 1'b0, 24'h0000a5},
		{1'b0, 10'h02b, 5'd3, 1'b1, 24'h000057}, {1'b1, 10'h2f1, 5'd2, 1'b0, 24'hf4f1f5}};
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic        slow = 1'b0;
	logic [1:0]  fault = 2'h0;
	logic [31:0] prdata, m_prdata, m_pwdata, rd;
	logic        pready, pslverr, m_psel, m_penable, m_pwrite, m_pready, stop, err, irq;
	logic [11:0] m_paddr;
	logic [23:0] wlog;
	logic [7:0]  nbyte;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	always #25 pclk = ~pclk;

	i2c_rx_host #(.MAX_BYTES(16)) u_i2c_rx_host (.pclk(pclk), .presetn(presetn),
		.s_psel(psel), .s_penable(penable), .s_pwrite(pwrite), .s_paddr(paddr),
		.s_pwdata(pwdata), .s_prdata(prdata), .s_pready(pready), .s_pslverr(pslverr),
		.m_psel(m_psel), .m_penable(m_penable), .m_pwrite(m_pwrite), .m_paddr(m_paddr),
		.m_pwdata(m_pwdata), .m_prdata(m_prdata), .m_pready(m_pready));
	dev_model u_dev_model (.pclk(pclk), .presetn(presetn), .slow(slow), .fault(fault),
		.psel(m_psel), .penable(m_penable), .pwrite(m_pwrite), .paddr(m_paddr),
		.pwdata(m_pwdata), .prdata(m_prdata), .pready(m_pready), .wlog_q(wlog),
		.nbyte_q(nbyte), .stop_q(stop), .err_irq(irq));

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask

	// Polls until busy drops; a hang is cut short by the cycle ceiling
	task automatic run(input logic ten, input logic [9:0] a, input logic [4:0] n);
		apb(1'b1, i2c_rx_host_pkg::REG_ADDR, {22'h0, a});
		apb(1'b1, i2c_rx_host_pkg::REG_COUNT, {27'h0, n});
		apb(1'b1, i2c_rx_host_pkg::REG_CTRL, {28'h0, 2'h3, ten, 1'b1});
		do
			apb(1'b0, i2c_rx_host_pkg::REG_STATUS, 32'h0);
		while (rd[i2c_rx_host_pkg::ST_BUSY] !== 1'b0);
	endtask

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_fail++;
			give_verdict();
		end
	end

	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ROWS[k])
		begin
			slow <= ROWS[k].sl;
			run(ROWS[k].ten, ROWS[k].a, ROWS[k].n);
			chk({19'h0, rd[12:0]}, {19'h0, ROWS[k].n, 8'h02});
			chk({8'h0, wlog}, {8'h0, ROWS[k].w});
			chk({24'h0, nbyte}, {27'h0, ROWS[k].n});
			chk({31'h0, stop}, 32'h1);
			chk({31'h0, irq}, 32'h0);
			for (int j = 0; j < ROWS[k].n; j++)
			begin
				apb(1'b0, i2c_rx_host_pkg::REG_DATA_BASE + 12'(j * 4), 32'h0);
				chk({24'h0, rd[7:0]}, {24'h0, 8'h30 + 8'(j)});
			end
			$display("row %0d done", k);
		end
		slow <= 1'b0;
		apb(1'b0, 12'h100, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, i2c_rx_host_pkg::REG_COUNT, 32'h0);
		apb(1'b1, i2c_rx_host_pkg::REG_CTRL, 32'h1);
		apb(1'b0, i2c_rx_host_pkg::REG_STATUS, 32'h0);
		chk({31'h0, rd[0]}, 32'h0);
		$display("refusal test done");
		for (int f = 1; f < 4; f++)
		begin
			fault <= 2'(f);
			run(1'b0, 10'h011, 5'd2);
			chk({28'h0, rd[4:1]}, {28'h0, (4'h1 << f) | 4'h1});
			chk({31'h0, stop}, {31'h0, f != 2});
			chk({31'h0, irq}, 32'h1);
			apb(1'b1, i2c_rx_host_pkg::REG_STATUS, 32'h1c);
			$display("fault %0d test done", f);
		end
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, i2c_rx_host_pkg::REG_STATUS, 32'h0);
		chk(rd, 32'h0);
		$display("reset test done");
		give_verdict();
	end
endmodule

`default_nettype wire
